/* File: servo_drive_end.sv */
// Drive end: switch capture, limit gating, overtravel stop and encoder pulse output
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module servo_drive_end #(
   parameter int DB_CYC = servo_pkg::DB_CYCLES,
   parameter int DECEL_CYC = servo_pkg::DECEL_CYCLES,
   parameter int ENC_DIV = servo_pkg::ENC_DIV_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Host link
   servo_link_if.drive link,
   // Setting switches
   input wire logic [3:0] upper_address_switch,
   input wire logic [3:0] lower_address_switch,
   input wire logic [3:0] link_config_switch,
   // Limit switches from the io connector
   input wire logic forward_limit_in,
   input wire logic reverse_limit_in,
   // Power stage and encoder emulation
   output logic motor_run,
   output logic motor_ccw,
   output logic dyn_brake,
   output logic zero_clamp,
   output logic decel_active,
   output logic enc_pulse_a_out,
   output logic enc_pulse_b_out
);
   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_BRAKE, ST_DECEL, ST_HOLD} drv_state_t;
   typedef struct packed {
      drv_state_t st;
      logic [7:0] addr;
      logic addr_ok;
      logic [5:0] fbytes;
      logic frame_ok;
      logic dir_sel;
      logic fwd_en;
      logic rev_en;
      logic [7:0] stop_p;
      logic [2:0] cap_cnt;
      logic cfg_ready;
      logic run_fwd;
      servo_pkg::hold_t hold;
      logic [31:0] tmr;
      logic [15:0] enc_div;
      logic [1:0] enc_ph;
      logic enc_a;
      logic enc_b;
   } drv_t;
   drv_t d_r;
   drv_t d_nxt;
   logic [13:0] pins_s;
   logic fwd_ok;
   logic rev_ok;
   logic want_fwd;
   logic want_rev;
   logic blocked;
   logic [7:0] sw_addr;

   // Switches and limits are asynchronous to sys_clk
   pin_sync #(.W(14)) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin({forward_limit_in, reverse_limit_in, link_config_switch, upper_address_switch,
         lower_address_switch}),
      .level(pins_s)
   );

   function automatic logic [5:0] frame_len(input logic [1:0] code);
      case (code)
         2'h0: frame_len = servo_pkg::FRAME_16;
         2'h1: frame_len = servo_pkg::FRAME_32;
         default: frame_len = servo_pkg::FRAME_48;
      endcase
   endfunction

   assign sw_addr = pins_s[7:0];
   // Limit ON means travel allowed; a disabled limit always allows
   assign fwd_ok = !d_r.fwd_en || pins_s[13];
   assign rev_ok = !d_r.rev_en || pins_s[12];
   assign want_fwd = link.ref_fwd && !link.ref_rev;
   assign want_rev = link.ref_rev && !link.ref_fwd;
   assign blocked = d_r.run_fwd ? !fwd_ok : !rev_ok;

   always_comb
   begin
      d_nxt = d_r;
      // Settings are frozen between restarts
      if (link.restart)
      begin
         d_nxt.cap_cnt = servo_pkg::CAPTURE_WAIT;
         d_nxt.cfg_ready = 1'b0;
         d_nxt.st = ST_IDLE;
      end
      else if (!d_r.cfg_ready)
      begin
         // Wait lets the pin synchroniser settle before capture
         if (d_r.cap_cnt != 3'h0)
         begin
            d_nxt.cap_cnt = d_r.cap_cnt - 3'h1;
         end
         else
         begin
            d_nxt.cfg_ready = 1'b1;
            d_nxt.addr = sw_addr;
            d_nxt.addr_ok = sw_addr >= servo_pkg::ADDR_FIRST_OK
               && sw_addr <= servo_pkg::ADDR_LAST_OK;
            // Positions 3 and 4 are not looked at
            d_nxt.fbytes = frame_len(pins_s[9:8]);
            d_nxt.frame_ok = pins_s[9:8] != 2'h3;
            d_nxt.dir_sel = link.direction_select_param;
            d_nxt.fwd_en = link.fwd_limit_alloc_param != servo_pkg::ALLOC_OFF;
            d_nxt.rev_en = link.rev_limit_alloc_param != servo_pkg::ALLOC_OFF;
            d_nxt.stop_p = link.overtravel_stop_param;
         end
      end
      else
      begin
         case (d_r.st)
            ST_IDLE:
            begin
               if (want_fwd && fwd_ok)
               begin
                  d_nxt.st = ST_RUN;
                  d_nxt.run_fwd = 1'b1;
               end
               else if (want_rev && rev_ok)
               begin
                  d_nxt.st = ST_RUN;
                  d_nxt.run_fwd = 1'b0;
               end
            end
            ST_RUN:
            begin
               if (blocked)
               begin
                  d_nxt.tmr = 32'(DB_CYC - 1);
                  d_nxt.hold = servo_pkg::HOLD_DB;
                  d_nxt.st = ST_BRAKE;
                  if (d_r.stop_p[7:4] == servo_pkg::DECEL_CLAMP)
                  begin
                     d_nxt.st = ST_DECEL;
                     d_nxt.tmr = 32'(DECEL_CYC - 1);
                     d_nxt.hold = servo_pkg::HOLD_CLAMP;
                  end
                  else if (d_r.stop_p[7:4] == servo_pkg::DECEL_COAST)
                  begin
                     d_nxt.st = ST_DECEL;
                     d_nxt.tmr = 32'(DECEL_CYC - 1);
                     d_nxt.hold = servo_pkg::HOLD_COAST;
                  end
                  else if (d_r.stop_p[3:0] == servo_pkg::STOP_DB_COAST)
                  begin
                     d_nxt.hold = servo_pkg::HOLD_COAST;
                  end
                  else if (d_r.stop_p[3:0] != servo_pkg::STOP_DB_HOLD)
                  begin
                     // Any other code coasts with the stage switched off
                     d_nxt.st = ST_HOLD;
                     d_nxt.hold = servo_pkg::HOLD_COAST;
                  end
               end
               else if (!(d_r.run_fwd ? want_fwd : want_rev))
               begin
                  d_nxt.st = ST_IDLE;
               end
            end
            ST_BRAKE, ST_DECEL:
            begin
               if (d_r.tmr == 32'h0)
               begin
                  d_nxt.st = ST_HOLD;
               end
               else
               begin
                  d_nxt.tmr = d_r.tmr - 32'h1;
               end
            end
            ST_HOLD:
            begin
               // Released once the blocked direction is no longer asked for
               if (!(d_r.run_fwd ? want_fwd : want_rev))
               begin
                  d_nxt.st = ST_IDLE;
               end
            end
            default:
            begin
               d_nxt.st = ST_IDLE;
            end
         endcase
      end
      // Encoder emulation follows the reference sense, never the direction digit
      if (d_r.st == ST_RUN)
      begin
         if (d_r.enc_div == 16'(ENC_DIV - 1))
         begin
            d_nxt.enc_div = 16'h0;
            d_nxt.enc_ph = d_r.run_fwd ? d_r.enc_ph + 2'h1 : d_r.enc_ph - 2'h1;
            d_nxt.enc_a = d_nxt.enc_ph[1];
            d_nxt.enc_b = d_nxt.enc_ph[1] ^ d_nxt.enc_ph[0];
         end
         else
         begin
            d_nxt.enc_div = d_r.enc_div + 16'h1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         d_r <= '0;
         d_r.st <= ST_IDLE;
         d_r.addr <= servo_pkg::ADDR_DEFAULT;
         d_r.fbytes <= servo_pkg::FRAME_48;
         // Default address and frame are usable until the first capture
         d_r.addr_ok <= 1'b1;
         d_r.frame_ok <= 1'b1;
         d_r.cap_cnt <= servo_pkg::CAPTURE_WAIT;
         d_r.hold <= servo_pkg::HOLD_DB;
      end
      else
      begin
         d_r <= d_nxt;
      end
   end

   // Direction digit flips the motor sense; default forward is counterclockwise
   assign motor_ccw = d_r.run_fwd ^ d_r.dir_sel;
   assign motor_run = d_r.st == ST_RUN || d_r.st == ST_DECEL
      || (d_r.st == ST_HOLD && d_r.hold == servo_pkg::HOLD_CLAMP);
   assign dyn_brake = d_r.st == ST_BRAKE || (d_r.st == ST_HOLD && d_r.hold == servo_pkg::HOLD_DB);
   assign zero_clamp = d_r.st == ST_HOLD && d_r.hold == servo_pkg::HOLD_CLAMP;
   assign decel_active = d_r.st == ST_DECEL;
   assign enc_pulse_a_out = d_r.enc_a;
   assign enc_pulse_b_out = d_r.enc_b;

   assign link.station_addr = d_r.addr;
   assign link.addr_ok = d_r.addr_ok;
   assign link.frame_bytes = d_r.fbytes;
   assign link.frame_ok = d_r.frame_ok;
   assign link.cfg_ready = d_r.cfg_ready;
   assign link.fwd_ot = d_r.cfg_ready && !fwd_ok;
   assign link.rev_ot = d_r.cfg_ready && !rev_ok;
   assign link.moving = d_r.st == ST_RUN;
   assign link.stopping = d_r.st == ST_BRAKE || d_r.st == ST_DECEL;
   assign link.holding = d_r.st == ST_HOLD;
endmodule

/* File: servo_pkg.sv */
// Shared constants and types for the servo configuration and overtravel ends
//--------------------------------------------------------------
// How it works
// - Station address is upper nibble, lower nibble; default 03H
// - Addresses 00H to 02H are unusable
// - Addresses F0H to FFH unusable; top is EFH
// - Link switch 1,2 pick 16/32/48 byte frames
// - Both frame positions ON is reserved; default 48
// - Link switch positions 3 and 4 are ignored
// - Direction digit 1 reverses motor rotation only
// - Encoder pulse polarity ignores the direction digit
// - Default forward is counterclockwise from load end
// - Forward reference B leads; reverse reference A leads
// - Forward limit OFF blocks forward, flags overtravel
// - Reverse limit OFF blocks reverse, flags overtravel
// - Opposite direction still runs during overtravel
// - Passing travel range forces the motor to stop
// - Forward limit from pin at code 2; 8 disables
// - Reverse limit from pin at code 3; 8 disables
// - Overtravel stop: brake, coast or decel then hold
//--------------------------------------------------------------
package servo_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam logic [7:0] ADDR_DEFAULT = 8'h03;
   localparam logic [7:0] ADDR_FIRST_OK = 8'h03;
   localparam logic [7:0] ADDR_LAST_OK = 8'hef;
   localparam logic [1:0] FRAME_DEFAULT = 2'h2;
   localparam logic [5:0] FRAME_16 = 6'h10;
   localparam logic [5:0] FRAME_32 = 6'h20;
   localparam logic [5:0] FRAME_48 = 6'h30;
   localparam logic [3:0] FWD_ALLOC_PIN = 4'h2;
   localparam logic [3:0] REV_ALLOC_PIN = 4'h3;
   localparam logic [3:0] ALLOC_OFF = 4'h8;
   localparam logic [3:0] STOP_DB_HOLD = 4'h0;
   localparam logic [3:0] STOP_DB_COAST = 4'h1;
   localparam logic [3:0] DECEL_CLAMP = 4'h1;
   localparam logic [3:0] DECEL_COAST = 4'h2;
   localparam int DB_TIME_US = 100;
   localparam int DECEL_TIME_US = 200;
   localparam int DB_CYCLES = DB_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int DECEL_CYCLES = DECEL_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int ENC_DIV_CYCLES = 25;
   localparam logic [2:0] CAPTURE_WAIT = 3'h5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_PARAM = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
   localparam logic [31:0] PARAM_RESET = 32'h0000_0320;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {HOLD_DB, HOLD_COAST, HOLD_CLAMP} hold_t;
endpackage

/* File: servo_link_if.sv */
// Link between the host motion controller end and the drive end
`timescale 1ns/1ps
interface servo_link_if;
   logic ref_fwd;
   logic ref_rev;
   logic restart;
   logic direction_select_param;
   logic [3:0] fwd_limit_alloc_param;
   logic [3:0] rev_limit_alloc_param;
   logic [7:0] overtravel_stop_param;
   logic [7:0] station_addr;
   logic addr_ok;
   logic [5:0] frame_bytes;
   logic frame_ok;
   logic cfg_ready;
   logic fwd_ot;
   logic rev_ot;
   logic moving;
   logic stopping;
   logic holding;
   modport drive (input ref_fwd, ref_rev, restart, direction_select_param, fwd_limit_alloc_param,
      rev_limit_alloc_param, overtravel_stop_param, output station_addr, addr_ok, frame_bytes,
      frame_ok, cfg_ready, fwd_ot, rev_ot, moving, stopping, holding);
   modport host (output ref_fwd, ref_rev, restart, direction_select_param, fwd_limit_alloc_param,
      rev_limit_alloc_param, overtravel_stop_param, input station_addr, addr_ok, frame_bytes,
      frame_ok, cfg_ready, fwd_ot, rev_ot, moving, stopping, holding);
endinterface

/* File: pin_sync.sv */
// Three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Pins and filtered result
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_t;
   sync_t sy_r;
   sync_t sy_nxt;

   always_comb
   begin
      sy_nxt = sy_r;
      sy_nxt.s1 = pin;
      sy_nxt.s2 = sy_r.s1;
      sy_nxt.s3 = sy_r.s2;
      for (int i = 0; i < W; i++)
      begin
         if (sy_r.s2[i] == sy_r.s3[i])
         begin
            sy_nxt.q[i] = sy_r.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         sy_r <= '0;
      end
      else
      begin
         sy_r <= sy_nxt;
      end
   end

   assign level = sy_r.q;
endmodule

/* File: servo_host_end.sv */
// Host controller end: AXI4-Lite register file driving the drive link
`timescale 1ns/1ps
module servo_host_end (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // AXI4-Lite slave
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq,
   // Drive link
   servo_link_if.host link
);
   typedef struct packed {
      logic aw_got;
      logic [4:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [1:0] refs;
      logic restart;
      logic [31:0] param;
      logic [2:0] ist;
      logic [2:0] imask;
      logic [2:0] ev_prev;
   } host_t;
   host_t h_r;
   host_t h_nxt;
   logic [31:0] status;
   logic [2:0] ev_now;
   logic [2:0] ev;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      for (int i = 0; i < 4; i++)
      begin
         merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   function automatic logic mapped(input logic [4:0] a);
      mapped = a == servo_pkg::OFS_CTRL || a == servo_pkg::OFS_PARAM || a == servo_pkg::OFS_STATUS
         || a == servo_pkg::OFS_IRQ_STAT || a == servo_pkg::OFS_IRQ_MASK;
   endfunction

   assign status = {8'h0, link.holding, link.stopping, link.moving, link.rev_ot, link.fwd_ot,
      link.cfg_ready, link.frame_ok, link.addr_ok, 2'h0, link.frame_bytes, link.station_addr};
   assign ev_now = {link.holding, link.rev_ot, link.fwd_ot};
   assign ev = ev_now & ~h_r.ev_prev;
   assign s_axi_awready = !h_r.aw_got && !h_r.bvalid;
   assign s_axi_wready = !h_r.w_got && !h_r.bvalid;
   assign s_axi_arready = !h_r.rvalid;

   always_comb
   begin
      h_nxt = h_r;
      h_nxt.restart = 1'b0;
      h_nxt.ev_prev = ev_now;
      h_nxt.ist = h_r.ist | ev;
      if (s_axi_awvalid && s_axi_awready)
      begin
         h_nxt.aw_got = 1'b1;
         h_nxt.aw_addr = {s_axi_awaddr[4:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         h_nxt.w_got = 1'b1;
         h_nxt.w_data = s_axi_wdata;
         h_nxt.w_strb = s_axi_wstrb;
      end
      if (h_r.aw_got && h_r.w_got)
      begin
         h_nxt.aw_got = 1'b0;
         h_nxt.w_got = 1'b0;
         h_nxt.bvalid = 1'b1;
         h_nxt.bresp = mapped(h_r.aw_addr) ? servo_pkg::RESP_OKAY : servo_pkg::RESP_SLVERR;
         case (h_r.aw_addr)
            servo_pkg::OFS_CTRL:
            begin
               h_nxt.refs = h_r.w_strb[0] ? h_r.w_data[1:0] : h_r.refs;
               // Restart is a one-cycle pulse that makes the drive recapture
               h_nxt.restart = h_r.w_strb[0] && h_r.w_data[2];
            end
            servo_pkg::OFS_PARAM: h_nxt.param = merge(h_r.param, h_r.w_data, h_r.w_strb);
            // New events in the same cycle survive the clear
            servo_pkg::OFS_IRQ_STAT: h_nxt.ist = (h_r.ist & ~h_r.w_data[2:0]) | ev;
            servo_pkg::OFS_IRQ_MASK: h_nxt.imask = h_r.w_strb[0] ? h_r.w_data[2:0] : h_r.imask;
            default: h_nxt.refs = h_r.refs;
         endcase
      end
      if (h_r.bvalid && s_axi_bready)
      begin
         h_nxt.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         h_nxt.rvalid = 1'b1;
         h_nxt.rresp = mapped({s_axi_araddr[4:2], 2'h0}) ? servo_pkg::RESP_OKAY : servo_pkg::RESP_SLVERR;
         case ({s_axi_araddr[4:2], 2'h0})
            servo_pkg::OFS_CTRL: h_nxt.rdata = {30'h0, h_r.refs};
            servo_pkg::OFS_PARAM: h_nxt.rdata = h_r.param;
            servo_pkg::OFS_STATUS: h_nxt.rdata = status;
            servo_pkg::OFS_IRQ_STAT: h_nxt.rdata = {29'h0, h_r.ist};
            servo_pkg::OFS_IRQ_MASK: h_nxt.rdata = {29'h0, h_r.imask};
            default: h_nxt.rdata = 32'h0;
         endcase
      end
      else if (h_r.rvalid && s_axi_rready)
      begin
         h_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         h_r <= '0;
         h_r.param <= servo_pkg::PARAM_RESET;
      end
      else
      begin
         h_r <= h_nxt;
      end
   end

   assign s_axi_bvalid = h_r.bvalid;
   assign s_axi_bresp = h_r.bresp;
   assign s_axi_rvalid = h_r.rvalid;
   assign s_axi_rresp = h_r.rresp;
   assign s_axi_rdata = h_r.rdata;
   assign irq = |(h_r.ist & h_r.imask);

   assign link.ref_fwd = h_r.refs[0];
   assign link.ref_rev = h_r.refs[1];
   assign link.restart = h_r.restart;
   assign link.direction_select_param = h_r.param[0];
   assign link.fwd_limit_alloc_param = h_r.param[7:4];
   assign link.rev_limit_alloc_param = h_r.param[11:8];
   assign link.overtravel_stop_param = h_r.param[23:16];
endmodule

/* File: servo_station_cfg_overtravel_props.sv */
// Link checker between the host end and the drive end
`timescale 1ns/1ps
module servo_station_cfg_overtravel_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Link signals
   input wire logic ref_fwd,
   input wire logic ref_rev,
   input wire logic restart,
   input wire logic [7:0] station_addr,
   input wire logic addr_ok,
   input wire logic [5:0] frame_bytes,
   input wire logic frame_ok,
   input wire logic cfg_ready,
   input wire logic fwd_ot,
   input wire logic rev_ot,
   input wire logic moving,
   input wire logic stopping,
   input wire logic holding
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   logic fwd_only;
   logic rev_only;
   assign fwd_only = ref_fwd && !ref_rev;
   assign rev_only = ref_rev && !ref_fwd;
   // ----
   // Settings capture
   // ----
   a_addr_range: assert property (addr_ok == (station_addr >= 8'h03 && station_addr <= 8'hef))
      else $error("addr flag");
   a_frame_code: assert property (frame_ok |-> frame_bytes inside {6'h10, 6'h20, 6'h30})
      else $error("frame code");
   a_reset_values: assert property ($fell(reset) |-> station_addr == 8'h03 && frame_bytes == 6'h30 && !cfg_ready)
      else $error("reset values");
   a_capture_time: assert property ($fell(reset) |-> ##[1:8] cfg_ready)
      else $error("no capture");
   a_cfg_steady: assert property ($past(cfg_ready) && cfg_ready |-> $stable(station_addr) && $stable(frame_bytes))
      else $error("settings moved");
   a_restart_seq: assert property (restart |-> ##[1:2] !cfg_ready ##[1:9] cfg_ready)
      else $error("no recapture");
   // ----
   // Motion gating
   // ----
   a_fwd_block: assert property (fwd_ot && fwd_only |=> !moving)
      else $error("fwd run");
   a_rev_block: assert property (rev_ot && rev_only |=> !moving)
      else $error("rev run");
   a_escape_run: assert property (cfg_ready && !restart && rev_ot && !fwd_ot && fwd_only && !moving && !stopping
      && !holding |=> moving)
      else $error("no escape");
   a_stop_bound: assert property ($rose(stopping) |-> ##[1:20] !stopping)
      else $error("stop too long");
   a_stop_hold: assert property ($fell(stopping) |-> holding)
      else $error("no hold");
   c_escape: cover property (rev_ot && fwd_only && moving);
   c_hold: cover property (holding && fwd_ot);
   c_restart: cover property (restart);
   c_bad_addr: cover property (cfg_ready && !addr_ok);
endmodule

/* File: servo_station_cfg_overtravel_test.sv */
// Self-checking bench for the host end and drive end joined by their link
`timescale 1ns/1ps
module servo_station_cfg_overtravel_test;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [3:0] upper_address_switch = 4'h0, lower_address_switch = 4'h3, link_config_switch = 4'h2;
   logic forward_limit_in = 1'b1, reverse_limit_in = 1'b1;
   logic motor_run, motor_ccw, dyn_brake, zero_clamp, decel_active, enc_pulse_a_out, enc_pulse_b_out;
   int n_errors = 0, n_compared = 0, seed = 49688, cyc = 0;
   logic [7:0] corner [6] = '{8'h00, 8'h02, 8'h03, 8'hef, 8'hf0, 8'hff};
   logic [7:0] stop_code [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20};
   servo_link_if link ();
   servo_host_end servo_host_end_i (.*);
   servo_drive_end #(.DB_CYC(8), .DECEL_CYC(8), .ENC_DIV(2)) servo_drive_end_i (.*);
   servo_station_cfg_overtravel_props servo_station_cfg_overtravel_props_i (.sys_clk, .reset, .ref_fwd(link.ref_fwd),
      .ref_rev(link.ref_rev),
      .restart(link.restart), .station_addr(link.station_addr), .addr_ok(link.addr_ok),
      .frame_bytes(link.frame_bytes), .frame_ok(link.frame_ok), .cfg_ready(link.cfg_ready),
      .fwd_ot(link.fwd_ot), .rev_ot(link.rev_ot), .moving(link.moving), .stopping(link.stopping),
      .holding(link.holding));
   initial
      forever #10 sys_clk = ~sys_clk;
   initial
   begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         give_verdict;
      end
   end
   // ----
   // Tasks and expectations
   // ----
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bit ta, tw, tb;
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(negedge sys_clk);
         {ta, tw, tb, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge sys_clk);
         s_axi_awvalid <= s_axi_awvalid && !ta;
         s_axi_wvalid <= s_axi_wvalid && !tw;
      end
      while (!tb);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      bit ta, tr;
      @(posedge sys_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do
      begin
         @(negedge sys_clk);
         {ta, tr, rdat, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge sys_clk);
         s_axi_arvalid <= s_axi_arvalid && !ta;
      end
      while (!tr);
      s_axi_rready <= 1'b0;
   endtask
   task automatic boot(input logic [31:0] p);
      wr(servo_pkg::OFS_PARAM, p);
      wr(servo_pkg::OFS_CTRL, 32'h4);
      repeat (3) @(posedge sys_clk);
      rdat = 32'h0;
      for (int i = 0; i < 20 && rdat[18] !== 1'b1; i++)
         rd(servo_pkg::OFS_STATUS);
      chk(rdat[18], 1'b1);
   endtask
   task automatic enc_watch(input bit fwd);
      logic [1:0] p, q;
      int steps = 0, bad = 0;
      @(negedge sys_clk);
      p = {enc_pulse_a_out, enc_pulse_a_out ^ enc_pulse_b_out};
      repeat (40)
      begin
         @(negedge sys_clk);
         q = {enc_pulse_a_out, enc_pulse_a_out ^ enc_pulse_b_out};
         steps += q != p;
         bad += q != p && q != (fwd ? p + 2'h1 : p - 2'h1);
         p = q;
      end
      chk(steps > 8, 1'b1);
      chk(bad, 0);
   endtask
   function automatic logic aok(input logic [7:0] a);
      return a >= 8'h03 && a <= 8'hef;
   endfunction
   function automatic logic [5:0] frame(input logic [1:0] c);
      return {c + 2'h1, 4'h0};
   endfunction
   function automatic logic [1:0] stop_exp(input logic [7:0] s);
      return {s == 8'h00, s[7:4] == 4'h1};
   endfunction
   // ----
   // Main sequence
   // ----
   initial
   begin
      logic [7:0] a;
      logic [1:0] c;
      bit f;
      wait (!reset);
      repeat (10) @(posedge sys_clk);
      rd(servo_pkg::OFS_STATUS);
      chk(rdat[13:0], {6'h30, 8'h03});
      rd(servo_pkg::OFS_PARAM);
      chk(rdat, servo_pkg::PARAM_RESET);
      rd(5'h14);
      chk(resp, servo_pkg::RESP_SLVERR);
      wr(5'h18, 32'h1);
      chk(resp, servo_pkg::RESP_SLVERR);
      $display("Test defaults done");
      for (int i = 0; i < 10; i++)
      begin
         a = (i < 6) ? corner[i] : 8'($random(seed));
         c = 2'(i);
         {upper_address_switch, lower_address_switch} <= a;
         link_config_switch <= {2'($random(seed)), c};
         boot(servo_pkg::PARAM_RESET);
         chk(rdat[7:0], a);
         chk(rdat[16], aok(a));
         chk(rdat[17], c != 2'h3);
         if (c != 2'h3)
            chk(rdat[13:8], frame(c));
         upper_address_switch <= ~a[7:4];
         repeat (8) @(posedge sys_clk);
         rd(servo_pkg::OFS_STATUS);
         chk(rdat[7:0], a);
      end
      $display("Test switches done");
      for (int i = 0; i < 4; i++)
      begin
         boot(servo_pkg::PARAM_RESET | 32'(i[1]));
         wr(servo_pkg::OFS_CTRL, i[0] ? 32'h1 : 32'h2);
         repeat (3) @(negedge sys_clk);
         chk(motor_ccw, i[0] ^ i[1]);
         enc_watch(i[0]);
         wr(servo_pkg::OFS_CTRL, 32'h0);
      end
      $display("Test direction done");
      for (int k = 0; k < 5; k++)
      begin
         f = !k[0];
         boot(servo_pkg::PARAM_RESET | {8'h0, stop_code[k], 16'h0});
         wr(servo_pkg::OFS_IRQ_MASK, 32'h7);
         wr(servo_pkg::OFS_IRQ_STAT, 32'h7);
         wr(servo_pkg::OFS_CTRL, f ? 32'h1 : 32'h2);
         repeat (4) @(posedge sys_clk);
         forward_limit_in <= !f;
         reverse_limit_in <= f;
         repeat (40) @(negedge sys_clk);
         chk({dyn_brake, zero_clamp, decel_active}, {stop_exp(stop_code[k]), 1'b0});
         chk(irq, 1'b1);
         rd(servo_pkg::OFS_STATUS);
         chk({rdat[23], rdat[20:19]}, f ? 3'h5 : 3'h6);
         rd(servo_pkg::OFS_IRQ_STAT);
         chk(rdat[2:0], f ? 3'h5 : 3'h6);
         wr(servo_pkg::OFS_IRQ_MASK, 32'h0);
         wr(servo_pkg::OFS_IRQ_STAT, 32'h7);
         rd(servo_pkg::OFS_IRQ_STAT);
         chk(rdat[2:0], 3'h0);
         chk(irq, 1'b0);
         wr(servo_pkg::OFS_CTRL, f ? 32'h2 : 32'h1);
         repeat (4) @(negedge sys_clk);
         chk({motor_run, motor_ccw}, {1'b1, !f});
         wr(servo_pkg::OFS_CTRL, 32'h0);
         forward_limit_in <= 1'b1;
         reverse_limit_in <= 1'b1;
      end
      $display("Test overtravel done");
      for (int k = 0; k < 2; k++)
      begin
         forward_limit_in <= 1'b0;
         reverse_limit_in <= 1'b0;
         boot(k ? 32'h0000_0820 : 32'h0000_0380);
         wr(servo_pkg::OFS_CTRL, k ? 32'h2 : 32'h1);
         repeat (4) @(negedge sys_clk);
         chk(motor_run, 1'b1);
         rd(servo_pkg::OFS_STATUS);
         chk(rdat[20:19], k ? 2'h1 : 2'h2);
         wr(servo_pkg::OFS_CTRL, 32'h0);
      end
      $display("Test limit disable done");
      give_verdict;
   end
endmodule
